/* rtl/smb_pkg.sv */
// constants, types and register map of the submessage builder
// assumes a byte stream sink and a classic wishbone master outside
`default_nettype none
package smb_pkg;
   // submessage kinds
   localparam logic [7:0] KIND_PAD = 8'h01;
   localparam logic [7:0] KIND_DATA = 8'h02;
   localparam logic [7:0] KIND_NOKEY_DATA = 8'h03;
   localparam logic [7:0] KIND_ACKNACK = 8'h06;
   localparam logic [7:0] KIND_HEARTBEAT = 8'h07;
   localparam logic [7:0] KIND_GAP = 8'h08;
   localparam logic [7:0] KIND_INFO_TS = 8'h09;
   localparam logic [7:0] KIND_INFO_SRC = 8'h0c;
   localparam logic [7:0] KIND_INFO_REPLY_IP4 = 8'h0d;
   localparam logic [7:0] KIND_INFO_DST = 8'h0e;
   localparam logic [7:0] KIND_INFO_REPLY = 8'h0f;
   localparam logic [7:0] KIND_DATA_FRAG = 8'h10;
   localparam logic [7:0] KIND_NOKEY_DATA_FRAG = 8'h11;
   localparam logic [7:0] KIND_NACK_FRAG = 8'h12;
   localparam logic [7:0] KIND_HEARTBEAT_FRAG = 8'h13;
   localparam logic [7:0] KIND_VENDOR_FIRST = 8'h80;
   // flag masks
   localparam logic [7:0] FLAG_ENDIAN = 8'h01;
   localparam logic [7:0] FLAG_FINAL = 8'h02;
   localparam logic [7:0] FLAG_QOS = 8'h02;
   localparam logic [7:0] FLAG_DATA = 8'h04;
   // register byte offsets
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_STATUS = 6'h04;
   localparam logic [5:0] REG_READER = 6'h08;
   localparam logic [5:0] REG_WRITER = 6'h0c;
   localparam logic [5:0] REG_COUNT = 6'h10;
   localparam logic [5:0] REG_IPADDR = 6'h14;
   localparam logic [5:0] REG_IPPORT = 6'h18;
   localparam logic [5:0] REG_PAY0 = 6'h20;
   localparam int PAY_WORDS = 8;
   localparam logic [3:0] PAY_MAX = 4'h8;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [3:0] HDR_WORD = 4'h0;
   // control register layout
   typedef struct packed {
      logic start;
      logic [14:0] rsv;
      logic [3:0] nWords;
      logic zeroLen;
      logic flagB;
      logic flagA;
      logic little;
      logic [7:0] kind;
   } smb_ctrl_t;
   typedef struct packed {
      logic [7:0] data;
      logic last;
   } smb_tx_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_DRAIN = 2'b10
   } smb_state_t;
endpackage
`default_nettype wire

/* rtl/smb_submsg_builder.sv */
// submessage builder: assembles one submessage and streams it out bytewise
// assumes a wishbone classic master and a valid/ready byte sink
// Operation
// - four-octet header: kind, flags, 16-bit length
// - data kinds 0x02, 0x03, 0x10, 0x11
// - reliability kinds 0x06, 0x07, 0x08, 0x12, 0x13
// - info kinds 0x01, 0x09, 0x0c..0x0f
// - flag bit 0 selects byte order
// - unused flags sent zero, ignored received
// - acknack: reader, writer, set state, count
// - acknack flag 0x02 marks final
// - keyless data flag 0x02: inline qos present
// - keyless data flag 0x04: payload present
// - ipv4 locator: address word then port word
// - header layouts fixed in major version 2
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module smb_submsg_builder import smb_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // byte stream toward the transport
   output logic [7:0] txData,
   output logic txLast,
   output logic txValid,
   input wire logic txReady
);
   function automatic logic [31:0] cdr(input logic [31:0] v,
                                       input logic le);
      return le ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   smb_ctrl_t ctrl_reg;
   smb_state_t state_reg;
   smb_tx_t tx_reg;
   logic [31:0] readerId_reg, writerId_reg, count_reg;
   logic [31:0] ipAddr_reg, ipPort_reg;
   logic [31:0] pay_reg [0:PAY_WORDS-1];
   logic [31:0] rdat_reg, rdMux, curWord;
   logic done_reg, ack_reg, txValid_reg;
   logic [3:0] wIdx_reg;
   logic [1:0] bIdx_reg;

   // bus decode
   wire busReq = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire idle = (state_reg == ST_IDLE);
   // frame contents are frozen while a submessage is on its way
   wire wrOk = busReq & wb_we_i & idle;
   wire wrCtrl = wrOk & (wb_adr_i == REG_CTRL);
   wire wrStatus = busReq & wb_we_i & (wb_adr_i == REG_STATUS);
   wire wrPay = wrOk & wb_adr_i[5];
   wire [2:0] wrPayIdx = wb_adr_i[4:2];
   wire startReq = wrCtrl & wb_sel_i[3] & wb_dat_i[31];
   wire doneClr = wrStatus & wb_sel_i[0] & wb_dat_i[1];

   // kind decode
   wire [7:0] kind = ctrl_reg.kind;
   wire little = ctrl_reg.little;
   wire isVendor = (kind >= KIND_VENDOR_FIRST);
   wire isAck = (kind == KIND_ACKNACK);
   wire isNoKey = (kind == KIND_NOKEY_DATA);
   wire isNoKeyFrag = (kind == KIND_NOKEY_DATA_FRAG);
   wire isIp4 = (kind == KIND_INFO_REPLY_IP4);
   wire hasIds = isAck | isNoKey;
   wire [3:0] nW = (ctrl_reg.nWords > PAY_MAX) ? PAY_MAX : ctrl_reg.nWords;
   // a zero-length pad or timestamp must not carry a body
   wire noBody = ctrl_reg.zeroLen &
                 (kind == KIND_PAD || kind == KIND_INFO_TS);
   // index of the final word; word 0 is the header
   wire [3:0] lastIdx = noBody ? HDR_WORD :
                        isIp4 ? 4'h2 :
                        isAck ? 4'(4'h3 + nW) :
                        isNoKey ? 4'(4'h2 + nW) : nW;
   // zero length lets the sink run to message end
   wire [15:0] len16 = ctrl_reg.zeroLen ? 16'h0000 :
                       {10'h000, lastIdx, 2'h0};
   wire [15:0] lenWire = little ? {len16[7:0], len16[15:8]} : len16;
   // only flags that the kind defines are sent; the rest stay zero
   wire [7:0] flagAck = ctrl_reg.flagA ? FLAG_FINAL : 8'h00;
   wire [7:0] flagQos = ctrl_reg.flagA ? FLAG_QOS : 8'h00;
   wire [7:0] flagDat = ctrl_reg.flagB ? FLAG_DATA : 8'h00;
   wire [7:0] flagsOut = (little ? FLAG_ENDIAN : 8'h00) |
                         (isAck ? flagAck : 8'h00) |
                         (isNoKey ? (flagQos | flagDat) : 8'h00) |
                         (isNoKeyFrag ? flagQos : 8'h00);
   wire [3:0] payBase = hasIds ? 4'h3 : 4'h1;
   wire [3:0] payOff = 4'(wIdx_reg - payBase);
   wire [2:0] payIdx = payOff[2:0];

   always_comb begin
      curWord = cdr(pay_reg[payIdx], little);
      if (wIdx_reg == HDR_WORD) begin
         curWord = {kind, flagsOut, lenWire};
      end else if (isIp4 && wIdx_reg == 4'h1) begin
         curWord = cdr(ipAddr_reg, little);
      end else if (isIp4) begin
         curWord = cdr(ipPort_reg, little);
      end else if (hasIds && wIdx_reg == 4'h1) begin
         curWord = readerId_reg;
      end else if (hasIds && wIdx_reg == 4'h2) begin
         curWord = writerId_reg;
      end else if (isAck && wIdx_reg == lastIdx) begin
         curWord = cdr(count_reg, little);
      end
   end

   // first byte on the wire is the top byte of the word
   wire [4:0] sh = {~bIdx_reg, 3'h0};
   wire [31:0] shifted = curWord >> sh;
   wire slot = ~txValid_reg | txReady;
   wire emit = (state_reg == ST_SEND) & slot;
   wire lastByte = (wIdx_reg == lastIdx) & (bIdx_reg == 2'h3);
   wire doneEvt = (state_reg == ST_DRAIN) & txReady;

   always_comb begin
      rdMux = RST_WORD;
      if (wb_adr_i == REG_CTRL) begin
         rdMux = ctrl_reg;
      end else if (wb_adr_i == REG_STATUS) begin
         rdMux = {20'h00000, lastIdx, 6'h00, done_reg, ~idle};
      end else if (wb_adr_i == REG_READER) begin
         rdMux = readerId_reg;
      end else if (wb_adr_i == REG_WRITER) begin
         rdMux = writerId_reg;
      end else if (wb_adr_i == REG_COUNT) begin
         rdMux = count_reg;
      end else if (wb_adr_i == REG_IPADDR) begin
         rdMux = ipAddr_reg;
      end else if (wb_adr_i == REG_IPPORT) begin
         rdMux = ipPort_reg;
      end else if (wb_adr_i[5]) begin
         rdMux = pay_reg[wb_adr_i[4:2]];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
         rdat_reg <= RST_WORD;
      end else begin
         ack_reg <= busReq;
         if (busReq) begin
            rdat_reg <= rdMux;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= RST_WORD;
         readerId_reg <= RST_WORD;
         writerId_reg <= RST_WORD;
         count_reg <= RST_WORD;
         ipAddr_reg <= RST_WORD;
         ipPort_reg <= RST_WORD;
      end else begin
         if (wrCtrl) begin
            ctrl_reg <= merge(ctrl_reg, wb_dat_i & 32'h0000_ffff, wb_sel_i);
         end
         if (wrOk & (wb_adr_i == REG_READER)) begin
            readerId_reg <= merge(readerId_reg, wb_dat_i, wb_sel_i);
         end
         if (wrOk & (wb_adr_i == REG_WRITER)) begin
            writerId_reg <= merge(writerId_reg, wb_dat_i, wb_sel_i);
         end
         if (wrOk & (wb_adr_i == REG_COUNT)) begin
            count_reg <= merge(count_reg, wb_dat_i, wb_sel_i);
         end
         if (wrOk & (wb_adr_i == REG_IPADDR)) begin
            ipAddr_reg <= merge(ipAddr_reg, wb_dat_i, wb_sel_i);
         end
         if (wrOk & (wb_adr_i == REG_IPPORT)) begin
            ipPort_reg <= merge(ipPort_reg, wb_dat_i, wb_sel_i);
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PAY_WORDS; i++) begin
            pay_reg[i] <= RST_WORD;
         end
      end else if (wrPay) begin
         pay_reg[wrPayIdx] <= merge(pay_reg[wrPayIdx], wb_dat_i, wb_sel_i);
      end
   end

   // sequencer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         wIdx_reg <= HDR_WORD;
         bIdx_reg <= 2'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (startReq) begin
                  state_reg <= ST_SEND;
                  wIdx_reg <= HDR_WORD;
                  bIdx_reg <= 2'h0;
               end
            end
            ST_SEND: begin
               if (slot) begin
                  bIdx_reg <= 2'(bIdx_reg + 2'h1);
                  if (bIdx_reg == 2'h3) begin
                     wIdx_reg <= 4'(wIdx_reg + 4'h1);
                  end
                  if (lastByte) begin
                     state_reg <= ST_DRAIN;
                  end
               end
            end
            ST_DRAIN: begin
               if (txReady) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_reg <= '0;
         txValid_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         if (emit) begin
            tx_reg <= '{data: shifted[7:0], last: lastByte};
            txValid_reg <= 1'b1;
         end else if (txReady) begin
            txValid_reg <= 1'b0;
         end
         // a completion in the clearing cycle is kept
         done_reg <= doneEvt | (done_reg & ~doneClr);
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
   assign txData = tx_reg.data;
   assign txLast = tx_reg.last;
   assign txValid = txValid_reg;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence sentHdr0;
      emit && wIdx_reg == 4'h0 && bIdx_reg == 2'h0;
   endsequence
   sequence sentHdr1;
      emit && wIdx_reg == 4'h0 && bIdx_reg == 2'h1;
   endsequence
   sequence sentHdr3;
      emit && wIdx_reg == 4'h0 && bIdx_reg == 2'h3;
   endsequence

   kind_byte_a: assert property (sentHdr0 |=> txValid &&
      txData == $past(ctrl_reg.kind))
      else $error("first header byte is not the kind");
   endian_flag_a: assert property (sentHdr1 |=>
      txData[0] == $past(ctrl_reg.little))
      else $error("byte order flag wrong");
   ack_flags_a: assert property (sentHdr1 ##0 isAck |=>
      txData == {6'h00, $past(ctrl_reg.flagA), $past(ctrl_reg.little)})
      else $error("acknack flags wrong");
   nokey_flags_a: assert property (sentHdr1 ##0 isNoKey |=>
      txData[7:1] == {5'h00, $past(ctrl_reg.flagB), $past(ctrl_reg.flagA)})
      else $error("keyless data flags wrong");
   other_flags_a: assert property (sentHdr1 ##0 (isVendor ||
      kind == KIND_GAP) |=> txData[7:1] == 7'h00)
      else $error("unused flag bits not zero");
   ip4_len_a: assert property (sentHdr3 ##0 (isIp4 && !little &&
      !ctrl_reg.zeroLen) |=> txData == 8'h08)
      else $error("locator submessage length not eight");
   len_little_a: assert property (emit && wIdx_reg == 4'h0 &&
      bIdx_reg == 2'h2 && little |=> txData == $past(len16[7:0]))
      else $error("little endian length low byte not first");
   hold_byte_a: assert property (txValid && !txReady |=>
      txValid && $stable(txData) && $stable(txLast))
      else $error("byte changed while stalled");
   ack_count_a: assert property (emit && isAck && lastByte |=>
      txLast && txData == $past(little ? count_reg[31:24] : count_reg[7:0]))
      else $error("acknack does not end on count");
   done_end_a: assert property (doneEvt |=> done_reg && idle)
      else $error("completion not recorded");
   pad_nobody_a: assert property (sentHdr3 ##0 noBody |=> txLast)
      else $error("zero-length pad carries a body");
endmodule // smb_submsg_builder
`default_nettype wire

/* bench/smb_sink_model.sv */
// byte sink standing in for the remote participant
// assumes the builder's valid/ready byte stream on the same clock
`timescale 1ns/1ps
`default_nettype none
module smb_sink_model import smb_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // byte stream
   input wire logic [7:0] txData,
   input wire logic txLast,
   input wire logic txValid,
   output logic txReady,
   // pacing: stall every other cycle when set
   input wire logic slow
);
   smb_tx_t got[$];
   logic phase;
   assign txReady = phase | ~slow;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= 1'b0;
      end else begin
         phase <= ~phase;
         // header layout is fixed, so octets are kept raw in arrival order
         if (txValid && txReady) got.push_back('{txData, txLast});
      end
   end
endmodule // smb_sink_model
`default_nettype wire

/* bench/test_smb_submsg_builder.sv */
// self-checking bench for the submessage builder
// assumes the sink model beside it and a 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_smb_submsg_builder import smb_pkg::*;;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
$display("mismatch at %0t got %h exp %h", $time, g, e); end end
   localparam logic [31:0] RDR = 32'h1122_3344;
   localparam logic [31:0] WTR = 32'h5566_7788;
   localparam logic [31:0] CNT = 32'h0000_0005;
   localparam logic [31:0] IPA = 32'hc0a8_0001;
   localparam logic [31:0] IPP = 32'h0000_1e61;
   logic mclk, rst_n, cyc, stb, we, ack, slow;
   logic [5:0] adr;
   logic [3:0] sel;
   logic [31:0] dw, dr, rd;
   logic [7:0] txData;
   logic txLast, txValid, txReady;
   logic [31:0] pay [8];
   logic [7:0] exq[$];
   int fails, cmp_count;

   smb_submsg_builder dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .txData(txData),
      .txLast(txLast), .txValid(txValid), .txReady(txReady));
   smb_sink_model sink (.mclk(mclk), .rst_n(rst_n), .txData(txData),
      .txLast(txLast), .txValid(txValid), .txReady(txReady), .slow(slow));

   task automatic wrap_up();
      if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d, input logic [3:0] s);
      int k = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      sel <= s;
      do begin
         @(posedge mclk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (ack !== 1'b1) begin
         fails++;
         wrap_up();
      end
      rd = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   function automatic logic [31:0] sw(input logic [31:0] x);
      return {x[7:0], x[15:8], x[23:16], x[31:24]};
   endfunction

   // builds the expected octets, starts one submessage and checks it
   task automatic run(input logic [7:0] kd, input logic le, fa, fb, zl,
      input logic [3:0] n, input logic sl);
      logic [31:0] w[$];
      logic [15:0] len;
      logic [7:0] fl;
      int k = 0;
      if (kd == KIND_ACKNACK || kd == KIND_NOKEY_DATA) w = {RDR, WTR};
      for (int i = 0; i < 8; i++)
         if (i < n && kd != KIND_INFO_REPLY_IP4)
            w.push_back(le ? sw(pay[i]) : pay[i]);
      if (kd == KIND_ACKNACK) w.push_back(le ? sw(CNT) : CNT);
      if (kd == KIND_INFO_REPLY_IP4)
         w = {le ? sw(IPA) : IPA, le ? sw(IPP) : IPP};
      if (zl && (kd == KIND_PAD || kd == KIND_INFO_TS)) w.delete();
      fl = {5'h0, fb && kd == KIND_NOKEY_DATA, fa && (kd == KIND_ACKNACK ||
         kd == KIND_NOKEY_DATA || kd == KIND_NOKEY_DATA_FRAG), le};
      len = zl ? 16'h0 : 16'(4 * w.size());
      exq = {kd, fl, le ? len[7:0] : len[15:8], le ? len[15:8] : len[7:0]};
      foreach (w[i]) begin
         exq = {exq, w[i][31:24], w[i][23:16], w[i][15:8], w[i][7:0]};
      end
      sink.got.delete();
      slow <= sl;
      bus(1'b1, REG_CTRL, {1'b1, 15'h0, n, zl, fb, fa, le, kd}, 4'hf);
      if (sl) begin
         bus(1'b0, REG_STATUS, 32'h0, 4'hf);
         `CHK(rd[0], 1'b1)
         // a busy builder must not pick up a new reader id mid-frame
         bus(1'b1, REG_READER, 32'hdead_beef, 4'hf);
      end
      while (sink.got.size() < exq.size() && k < 400) begin
         @(posedge mclk);
         k++;
      end
      if (sink.got.size() < exq.size()) begin
         fails++;
         wrap_up();
      end
      `CHK(sink.got.size(), exq.size())
      foreach (exq[i]) begin
         `CHK(sink.got[i].data, exq[i])
         `CHK(sink.got[i].last, i == exq.size() - 1)
      end
      bus(1'b0, REG_STATUS, 32'h0, 4'hf);
      `CHK(rd[1:0], 2'b10)
      bus(1'b1, REG_STATUS, 32'h2, 4'h1);
      bus(1'b0, REG_STATUS, 32'h0, 4'hf);
      `CHK(rd[1:0], 2'b00)
      bus(1'b0, REG_READER, 32'h0, 4'hf);
      `CHK(rd, RDR)
   endtask

   task automatic t_kinds();
      logic [7:0] ks[17] = '{8'h00, 8'h7f, KIND_PAD, KIND_DATA,
         KIND_NOKEY_DATA, KIND_ACKNACK, KIND_HEARTBEAT, KIND_GAP,
         KIND_INFO_TS, KIND_INFO_SRC, KIND_INFO_REPLY_IP4, KIND_INFO_DST,
         KIND_INFO_REPLY, KIND_DATA_FRAG, KIND_NOKEY_DATA_FRAG,
         KIND_NACK_FRAG, KIND_HEARTBEAT_FRAG};
      foreach (ks[i]) begin
         run(ks[i], 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
      end
   endtask

   task automatic t_ack();
      run(KIND_ACKNACK, 1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 1'b1);
      run(KIND_ACKNACK, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2, 1'b0);
   endtask

   task automatic t_nokey();
      run(KIND_NOKEY_DATA, 1'b0, 1'b1, 1'b1, 1'b0, 4'h2, 1'b0);
      run(KIND_NOKEY_DATA, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 1'b1);
      run(KIND_HEARTBEAT, 1'b0, 1'b1, 1'b1, 1'b0, 4'h1, 1'b0);
      run(KIND_NOKEY_DATA_FRAG, 1'b0, 1'b1, 1'b1, 1'b0, 4'h0, 1'b0);
   endtask

   task automatic t_len();
      run(8'h80, 1'b0, 1'b1, 1'b1, 1'b1, 4'hf, 1'b0);
      run(8'hff, 1'b1, 1'b0, 1'b0, 1'b0, 4'h8, 1'b0);
      run(KIND_PAD, 1'b0, 1'b0, 1'b0, 1'b1, 4'h2, 1'b0);
      run(KIND_INFO_TS, 1'b1, 1'b0, 1'b0, 1'b1, 4'h1, 1'b0);
      run(KIND_INFO_REPLY_IP4, 1'b1, 1'b1, 1'b0, 1'b0, 4'h3, 1'b1);
      run(KIND_INFO_REPLY_IP4, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
   endtask

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   initial begin
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 6'h0;
      sel = 4'h0;
      dw = 32'h0;
      slow = 1'b0;
      fails = 0;
      cmp_count = 0;
      foreach (pay[i]) pay[i] = 32'ha0b1_c2d3 + 32'h0101_0101 * i;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      bus(1'b0, REG_STATUS, 32'h0, 4'hf);
      `CHK(rd, RST_WORD)
      bus(1'b1, 6'h1c, 32'hffff_ffff, 4'hf);
      bus(1'b0, 6'h1c, 32'h0, 4'hf);
      `CHK(rd, 32'h0)
      bus(1'b1, REG_READER, RDR, 4'hf);
      bus(1'b1, REG_WRITER, WTR, 4'hf);
      bus(1'b1, REG_COUNT, CNT, 4'hf);
      bus(1'b1, REG_IPADDR, IPA, 4'hf);
      bus(1'b1, REG_IPPORT, IPP, 4'hf);
      foreach (pay[i]) bus(1'b1, REG_PAY0 + 6'(4 * i), pay[i], 4'hf);
      t_kinds();
      t_ack();
      t_nokey();
      t_len();
      wrap_up();
   end
endmodule // test_smb_submsg_builder
`default_nettype wire
